// ---- verilog/irac_host.sv ----
// bus master that reads and writes the register space of a current monitor
`timescale 1ns/1ps
// What this block does
// - last read byte answered with nack
// - direction bit clear writes, set reads
// - location byte follows write address byte
// - single write: start, addr, loc, data, stop
// - at most eight data bytes per write
// - single read: start, addr, byte, nack, stop
// - dummy write then repeated start sets read
// - ack asks next byte, nack+stop ends
// - every byte goes most significant bit first
// - address byte always first after any start
// - ninth slot carries ack low, nack high
module irac_host #(
    parameter logic [6:0] DEV_ADDR = irac_pkg::DEV_ADDR_DEF,
    parameter int unsigned Q_CYC = irac_pkg::Q_CYC
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire irac_pkg::irac_cmd_t cmd,
    // answers
    output logic rd_valid,
    output logic [7:0] rd_data,
    output irac_pkg::irac_rsp_t rsp,
    // bus pins
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import irac_pkg::*;

    localparam int QW = $clog2(Q_CYC + 1);

    // ------------------------------------------------------------
    // data line synchroniser
    // ------------------------------------------------------------
    logic s1, s2, s3, sda_lvl, next_sda_lvl;

    always_comb begin
        next_sda_lvl = (s2 == s3) ? s3 : sda_lvl;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            sda_lvl <= 1'b1;
        end else begin
            s1 <= sda_i;
            s2 <= s1;
            s3 <= s2;
            sda_lvl <= next_sda_lvl;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    irac_state_t state, next_state;
    irac_phase_t phase, next_phase;
    irac_cmd_t c, next_c;
    logic [QW-1:0] qcnt, next_qcnt;
    logic [1:0] qtr, next_qtr;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [3:0] idx, next_idx;
    logic [7:0] tx, next_tx;
    logic [7:0] rx, next_rx;
    logic nack, next_nack;
    logic scl, next_scl;
    logic sda_low, next_sda_low;
    logic next_rd_valid;
    logic [7:0] next_rd_data;
    irac_rsp_t next_rsp;
    logic tick, rxing, last;

    assign tick = (qcnt == QW'(Q_CYC - 1));
    assign rxing = (phase == PH_RDATA);
    // a zero count on a read still fetches one byte
    assign last = ({1'b0, idx} + 5'h01) >= {1'b0, c.count};

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_c = c;
        next_qtr = qtr;
        next_bit_cnt = bit_cnt;
        next_idx = idx;
        next_tx = tx;
        next_rx = rx;
        next_nack = nack;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_rsp = '0;
        next_qcnt = (state == ST_IDLE || tick) ? '0 : QW'(qcnt + 1'b1);
        next_scl = 1'b1;
        next_sda_low = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (cmd_valid) begin
                    next_c = cmd;
                    next_state = ST_START;
                    next_qtr = Q_FALL;
                    next_idx = '0;
                    next_nack = 1'b0;
                    // no location byte means the device counter picks the spot
                    next_phase = (cmd.rd && !cmd.set_loc) ? PH_ADDR_R : PH_ADDR_W;
                end
            end
            ST_START: begin
                // clock low again in q3 so the first data bit never moves under a high clock
                next_scl = (qtr == Q_RISE) || (qtr == Q_SAMPLE);
                next_sda_low = (qtr >= Q_SAMPLE);
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    if (qtr == Q_LAST) begin
                        next_state = ST_BYTE;
                        next_bit_cnt = '0;
                        next_tx = {DEV_ADDR, (phase == PH_ADDR_R) ? RW_READ : RW_WRITE};
                    end
                end
            end
            ST_BYTE: begin
                next_scl = (qtr == Q_RISE) || (qtr == Q_SAMPLE);
                if (bit_cnt != ACK_BIT) begin
                    next_sda_low = !rxing && !tx[3'(MSB_IDX - bit_cnt)];
                end else begin
                    next_sda_low = rxing && !last;
                end
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    if (qtr == Q_SAMPLE) begin
                        if (bit_cnt == ACK_BIT) begin
                            next_nack = !rxing && sda_lvl;
                        end else begin
                            next_rx = {rx[6:0], sda_lvl};
                        end
                    end
                    if (qtr == Q_LAST) begin
                        next_bit_cnt = (bit_cnt == ACK_BIT) ? '0 : bit_cnt + 4'h1;
                    end
                    if (qtr == Q_LAST && bit_cnt == ACK_BIT) begin
                        if (nack) begin
                            // a refused byte leaves nothing useful to do but stop
                            next_state = ST_STOP;
                        end else begin
                            unique case (phase)
                                PH_ADDR_W: begin
                                    next_tx = c.loc;
                                    next_phase = PH_LOC;
                                end
                                PH_LOC: begin
                                    if (c.rd) begin
                                        next_state = ST_START;
                                        next_phase = PH_ADDR_R;
                                    end else if (c.count == '0) begin
                                        next_state = ST_STOP;
                                    end else begin
                                        next_tx = c.wdata[0];
                                        next_phase = PH_WDATA;
                                        next_idx = 4'h1;
                                    end
                                end
                                PH_WDATA: begin
                                    if (idx >= c.count || idx >= MAX_WR) begin
                                        next_state = ST_STOP;
                                    end else begin
                                        next_tx = c.wdata[idx[2:0]];
                                        next_idx = idx + 4'h1;
                                    end
                                end
                                PH_ADDR_R: begin
                                    next_phase = PH_RDATA;
                                    next_idx = '0;
                                end
                                PH_RDATA: begin
                                    next_rd_valid = 1'b1;
                                    next_rd_data = rx;
                                    next_idx = idx + 4'h1;
                                    if (last) begin
                                        next_state = ST_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
            end
            ST_STOP: begin
                next_scl = (qtr != Q_FALL);
                next_sda_low = (qtr < Q_SAMPLE);
                if (tick) begin
                    next_qtr = qtr + 2'h1;
                    if (qtr == Q_LAST) begin
                        next_state = ST_IDLE;
                        next_rsp.done = 1'b1;
                        next_rsp.nack = nack;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            phase <= PH_ADDR_W;
            c <= '0;
            qcnt <= '0;
            qtr <= Q_FALL;
            bit_cnt <= '0;
            idx <= '0;
            tx <= '0;
            rx <= '0;
            nack <= 1'b0;
            scl <= 1'b1;
            sda_low <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            rsp <= '0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            c <= next_c;
            qcnt <= next_qcnt;
            qtr <= next_qtr;
            bit_cnt <= next_bit_cnt;
            idx <= next_idx;
            tx <= next_tx;
            rx <= next_rx;
            nack <= next_nack;
            scl <= next_scl;
            sda_low <= next_sda_low;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            rsp <= next_rsp;
        end
    end

    // ------------------------------------------------------------
    // pins and handshake
    // ------------------------------------------------------------
    // the only master on the bus, so the clock is pushed, not pulled
    assign scl_o = scl;
    assign scl_oe = 1'b1;
    assign sda_o = 1'b0;
    assign sda_oe = sda_low;
    assign cmd_ready = (state == ST_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic byte_end;
    assign byte_end = (state == ST_BYTE) && tick && qtr == Q_LAST && bit_cnt == ACK_BIT;

    a_first_addr_byte: assert property ($rose(state == ST_BYTE) |-> bit_cnt == '0
        && tx[7:1] == DEV_ADDR && (phase == PH_ADDR_W || phase == PH_ADDR_R))
        else $error("first byte after start is not the address");
    a_rw_direction: assert property ($rose(state == ST_BYTE) |-> tx[0] == rxing
        || tx[0] == (phase == PH_ADDR_R)) else $error("direction bit wrong");
    a_loc_second: assert property ($rose(phase == PH_LOC) |->
        $past(phase) == PH_ADDR_W && tx == c.loc) else $error("location not second");
    a_write_limit: assert property (phase == PH_WDATA |-> idx <= MAX_WR)
        else $error("more than eight data bytes");
    a_msb_first: assert property (state == ST_BYTE && !rxing && bit_cnt < ACK_BIT
        && qtr == Q_RISE |-> sda_low == !tx[3'(MSB_IDX - bit_cnt)])
        else $error("bit order wrong");
    a_ack_release: assert property (state == ST_BYTE && !rxing && bit_cnt == ACK_BIT
        && qtr != Q_FALL |-> !sda_low) else $error("master holds data line in ack slot");
    a_last_nack: assert property (state == ST_BYTE && rxing && bit_cnt == ACK_BIT
        && qtr == Q_SAMPLE |-> sda_low == !last) else $error("ack or nack wrong");
    a_read_end_stop: assert property (byte_end && rxing && last && !nack |=>
        state == ST_STOP ##1 (state == ST_STOP)[*3]) else $error("no stop after nack");
    a_restart_read: assert property (byte_end && phase == PH_LOC && c.rd && !nack |=>
        state == ST_START && phase == PH_ADDR_R) else $error("no repeated start");
    a_sda_stable_high: assert property (state == ST_BYTE && scl && $past(scl) |->
        $stable(sda_low)) else $error("data changed while clock high");
    a_stop_release: assert property (state == ST_STOP && qtr == Q_LAST |-> scl
        && !sda_low) else $error("stop condition malformed");

    c_write_done: cover property (rsp.done && !rsp.nack && !c.rd);
    c_read_restart: cover property (rd_valid && c.rd && c.set_loc);
    c_read_multi: cover property (rd_valid && idx > 4'h1);
    c_nack_abort: cover property (rsp.done && rsp.nack);
endmodule // irac_host

// ---- shared/irac_pkg.sv ----
// constants, state codes and carriers for the register-access bus master
package irac_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SCL_HZ = 100_000;
    // quarter of a bus bit, least time so rounded up
    localparam int unsigned Q_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

    // ------------------------------------------------------------
    // bus layout
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_DEF = 7'h34;
    localparam logic [3:0] MAX_WR = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] MSB_IDX = 4'h7;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [1:0] Q_FALL = 2'h0;
    localparam logic [1:0] Q_RISE = 2'h1;
    localparam logic [1:0] Q_SAMPLE = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;

    // ------------------------------------------------------------
    // states and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_BYTE = 4'h4,
        ST_STOP = 4'h8
    } irac_state_t;

    typedef enum logic [4:0] {
        PH_ADDR_W = 5'h01,
        PH_LOC = 5'h02,
        PH_WDATA = 5'h04,
        PH_ADDR_R = 5'h08,
        PH_RDATA = 5'h10
    } irac_phase_t;

    typedef struct packed {
        logic rd;
        logic set_loc;
        logic [7:0] loc;
        logic [3:0] count;
        logic [7:0][7:0] wdata;
    } irac_cmd_t;

    typedef struct packed {
        logic done;
        logic nack;
    } irac_rsp_t;
endpackage

// ---- tb/irac_dev_model.sv ----
// behavioural device model on the far side of the bus master
`timescale 1ns/1ps
module irac_dev_model (
    // bus
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    // scenario controls
    input wire logic [6:0] dev_addr,
    input wire logic slow,
    input wire logic nack_wr
);
    logic [7:0] mem [256];
    logic [7:0] ptr, sh, tx;
    logic act, rd, xmit, first, locn, ack;
    int bitn;
    // ----------------------------------------
    // device behaviour
    // ----------------------------------------
    // pull low or release only, slow mode answers late in the low phase
    task automatic put(input logic v);
        sda_oe <= #(slow ? 300 : 2) v;
    endtask
    initial begin
        sda_oe = 1'b0;
        act = 1'b0;
        ptr = 8'h00;
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
    end
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        first = 1'b1;
        xmit = 1'b0;
        rd = 1'b0;
        bitn = 0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act) begin
        if (bitn < 8 && !xmit) sh = {sh[6:0], sda};
        if (bitn == 8 && xmit && sda) act = 1'b0;
        bitn = bitn + 1;
    end
    always @(negedge scl) begin
        if (act && !xmit && bitn == 8) begin
            ack = !(first && sh[7:1] != dev_addr);
            if (first && ack) rd = sh[0];
            if (!first && locn) ptr = sh;
            if (!first && !locn && !nack_wr) mem[ptr] = sh;
            if (!first && !locn && !nack_wr) ptr = ptr + 8'h01;
            ack = ack && (first || locn || !nack_wr);
            locn = first && !sh[0];
            first = 1'b0;
            act = ack;
            put(ack);
        end else if (act && xmit && bitn < 8) begin
            put(!tx[7 - bitn]);
        end else if (act && xmit && bitn == 8) begin
            put(1'b0);
            ptr = ptr + 8'h01;
        end else if (act && bitn == 9) begin
            bitn = 0;
            xmit = rd;
            tx = mem[ptr];
            put(rd && !tx[7]);
        end
    end
endmodule // irac_dev_model

// ---- tb/irac_host_tb.sv ----
// self-checking bench for the register-access bus master
`timescale 1ns/1ps
module irac_host_tb;
    import irac_pkg::*;
    logic clk, rst, cmd_valid, cmd_ready, rd_valid, scl_o, scl_oe, sda_oe, dev_oe;
    logic slow, nack_wr, scl, sda;
    logic [6:0] dev_addr;
    logic [7:0] rd_data, l, ref_ptr;
    logic [7:0] ref_mem [256];
    logic [7:0] rq [$];
    irac_cmd_t cmd;
    irac_rsp_t rsp, got_rsp;
    int n_fail, checks_done;
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = !(sda_oe | dev_oe);
    irac_host #(.Q_CYC(8)) DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data),
        .rsp(rsp), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe));
    irac_dev_model u_dev (.scl(scl), .sda(sda), .sda_oe(dev_oe), .dev_addr(dev_addr),
        .slow(slow), .nack_wr(nack_wr));
    always #20 clk = !clk;
    always @(negedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
    // ----------------------------------------
    // checking tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (exp !== got) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic run(input irac_cmd_t c);
        int n;
        rq.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check("busy", 0, cmd_ready);
        n = 0;
        got_rsp = '0;
        while (got_rsp.done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            got_rsp = rsp;
            n++;
        end
        check("done", 1, got_rsp.done);
        check("ready", 1, cmd_ready);
        check("idle bus", 2'h3, {scl, sda});
    endtask
    task automatic do_write(input logic [7:0] loc, input logic [3:0] cnt, input logic ok);
        irac_cmd_t c;
        int k;
        c = '0;
        c.loc = loc;
        c.count = cnt;
        for (int i = 0; i < 8; i++) c.wdata[i] = 8'($urandom);
        run(c);
        // count above eight is clamped by the master
        k = (cnt > 8) ? 8 : cnt;
        check("wr nack", !ok, got_rsp.nack);
        if (ok) for (int i = 0; i < k; i++) ref_mem[8'(loc + i)] = c.wdata[i];
        if (ok) ref_ptr = 8'(loc + k);
        for (int i = 0; i < 256; i++) check("mem", ref_mem[i], u_dev.mem[i]);
    endtask
    task automatic do_read(input logic set, input logic [7:0] loc, input logic [3:0] cnt);
        irac_cmd_t c;
        int k;
        c = '0;
        c.rd = 1'b1;
        c.set_loc = set;
        c.loc = loc;
        c.count = cnt;
        if (set) ref_ptr = loc;
        run(c);
        k = (cnt == 0) ? 1 : cnt;
        check("rd nack", 0, got_rsp.nack);
        check("rd count", k, rq.size());
        for (int i = 0; i < k; i++) check("rd data", ref_mem[8'(ref_ptr + i)], rq[i]);
        ref_ptr = 8'(ref_ptr + k);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        dev_addr = DEV_ADDR_DEF;
        slow = 1'b0;
        nack_wr = 1'b0;
        n_fail = 0;
        checks_done = 0;
        void'($urandom(77846));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        ref_ptr = 8'h00;
        foreach (ref_mem[i]) ref_mem[i] = u_dev.mem[i];
        for (int t = 0; t < 5; t++) begin
            @(posedge clk) slow <= t[0];
            l = 8'($urandom);
            do_write(l, 4'($urandom_range(1, 8)), 1'b1);
            do_read(1'b1, l, 4'($urandom_range(1, 15)));
        end
        $display("test random write and read done");
        do_write(8'hFC, 4'h9, 1'b1);
        do_read(1'b1, 8'hFB, 4'h7);
        do_read(1'b0, 8'h00, 4'h0);
        do_write(8'h10, 4'h0, 1'b1);
        do_read(1'b0, 8'h00, 4'h3);
        $display("test corners done");
        // wrong address must leave memory untouched
        @(posedge clk) dev_addr <= DEV_ADDR_DEF ^ 7'h01;
        do_write(8'h20, 4'h2, 1'b0);
        @(posedge clk) dev_addr <= DEV_ADDR_DEF;
        @(posedge clk) nack_wr <= 1'b1;
        do_write(8'h30, 4'h3, 1'b0);
        @(posedge clk) nack_wr <= 1'b0;
        do_read(1'b1, 8'h30, 4'h2);
        $display("test refusals done");
        complete_run();
    end
    initial begin
        repeat (95000) @(posedge clk);
        n_fail = n_fail + 1;
        $display("mismatch watchdog expected done seen timeout");
        complete_run();
    end
endmodule // irac_host_tb
